// ===== ebc_top.sv
// Window bus configuration registers with reset-strapped window 0
// Summary of operation
// R1 - Field 0: command one half clock late
// R2 - Field 1: command at strobe fall
// R3 - Tristate field 0 inserts one wait state
// R4 - Type: demux8, mux8, demux16, mux16
// R5 - Window 0 type loaded from port
// R6 - Lengthen field 1 gives long strobe
// R7 - Pin high zeroes window 0, else strap
`timescale 1ns/10ps
module ebc_top
    import ebc_pkg::*;
#(
    parameter int WIN_N = EBC_WIN_N
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic [2:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic external_access_pin_in,
    input wire logic [1:0] config_sample_port_in,
    input wire logic [2:0] win_sel_in,
    output logic [15:0] rdata_out,
    output logic cmd_half_delay_out,
    output logic tri_wait_out,
    output logic long_strobe_out,
    output logic wide_out,
    output logic muxed_out,
    output logic bus_active_out
);
    typedef struct packed {
        logic strap_done;
        logic [1:0] sync_fill;
        logic [2:0] pin_sync0;
        logic [2:0] pin_sync1;
        logic [WIN_N-1:0][15:0] cfg;
        logic [15:0] rdata;
        logic [4:0] dec;
    } ebc_state_s;

    ebc_state_s s_q;
    ebc_state_s s_d;
    logic [1:0] rst_sync_q;
    logic rst_n;
    logic [4:0] dec_w;
    logic [15:0] sel_cfg;

    function automatic logic win_ok(input logic [2:0] idx);
        return idx < 3'(WIN_N);
    endfunction : win_ok

    // Masked bits must never be stored in any window
    function automatic logic reserved_set(input logic [WIN_N-1:0][15:0] words);
        logic hit;
        hit = 1'b0;
        for (int w = 0; w < WIN_N; w++) begin
            hit = hit | (|(words[w] & ~EBC_WR_MASK));
        end
        return hit;
    endfunction : reserved_set

    // Runs on the raw pin reset, so it sits outside the state struct
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // Unmapped selection shows the all-zero word
    assign sel_cfg = win_ok(win_sel_in) ? s_q.cfg[win_sel_in] : EBC_RESET_VAL;

    ebc_decode u_dec (
        .cfg_in(sel_cfg),
        .cmd_half_delay_out(dec_w[0]),
        .tri_wait_out(dec_w[1]),
        .long_strobe_out(dec_w[2]),
        .wide_out(dec_w[3]),
        .muxed_out(dec_w[4])
    );

    always_comb begin
        s_d = s_q;
        // Pin and port are asynchronous: two flops each before use
        s_d.pin_sync0 = {config_sample_port_in, external_access_pin_in};
        s_d.pin_sync1 = s_q.pin_sync0;
        // Second flop holds a real pin sample only after two edges
        s_d.sync_fill = {s_q.sync_fill[0], 1'b1};
        s_d.rdata = 16'h0000;
        s_d.dec = dec_w;
        if (!s_q.strap_done) begin
            // Writes are dropped until the strap is taken
            if (s_q.sync_fill[1]) begin
                s_d.strap_done = 1'b1;
                s_d.cfg[0] = EBC_RESET_VAL; // [R7]
                if (!s_q.pin_sync1[0]) begin
                    s_d.cfg[0][EBC_POS_ACTIVE] = 1'b1; // [R7]
                    s_d.cfg[0][EBC_POS_LENGTHEN] = 1'b1; // [R7]
                    s_d.cfg[0][EBC_POS_TYPE_LO +: 2] = s_q.pin_sync1[2:1]; // [R5]
                end
            end
        end else if (wr_in && win_ok(addr_in)) begin
            s_d.cfg[addr_in] = wdata_in & EBC_WR_MASK;
        end
        if (rd_in && win_ok(addr_in)) begin
            s_d.rdata = s_q.cfg[addr_in];
        end
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            s_q.strap_done <= 1'b0;
            s_q.sync_fill <= 2'h0;
            s_q.pin_sync0 <= 3'h0;
            s_q.pin_sync1 <= 3'h0;
            s_q.cfg <= '0;
            s_q.rdata <= 16'h0000;
            s_q.dec <= 5'h00;
        end else begin
            s_q.strap_done <= s_d.strap_done;
            s_q.sync_fill <= s_d.sync_fill;
            s_q.pin_sync0 <= s_d.pin_sync0;
            s_q.pin_sync1 <= s_d.pin_sync1;
            s_q.cfg <= s_d.cfg;
            s_q.rdata <= s_d.rdata;
            s_q.dec <= s_d.dec;
        end
    end

    assign rdata_out = s_q.rdata;
    assign cmd_half_delay_out = s_q.dec[0];
    assign tri_wait_out = s_q.dec[1];
    assign long_strobe_out = s_q.dec[2];
    assign wide_out = s_q.dec[3];
    assign muxed_out = s_q.dec[4];
    assign bus_active_out = s_q.cfg[0][EBC_POS_ACTIVE];

    // Decoded outputs lag the selected word by one edge; the edge
    // right after release still shows the reset decode
    a_cmd_delay_map: assert property (@(posedge clk_in) disable iff (!rst_n) // [R1]
        $past(rst_n) |-> cmd_half_delay_out == !$past(sel_cfg[EBC_POS_CMD_DELAY]))
        else $error("command delay decode wrong");

    a_cmd_no_delay: assert property (@(posedge clk_in) disable iff (!rst_n) // [R2]
        $past(rst_n) && $past(sel_cfg[EBC_POS_CMD_DELAY]) |-> !cmd_half_delay_out)
        else $error("command delay not removed");

    a_tri_wait_map: assert property (@(posedge clk_in) disable iff (!rst_n) // [R3]
        $past(rst_n) |-> tri_wait_out != $past(sel_cfg[EBC_POS_TRI_WAIT]))
        else $error("tristate wait decode wrong");

    a_type_width: assert property (@(posedge clk_in) disable iff (!rst_n) // [R4]
        $past(rst_n) |-> {wide_out, muxed_out} == $past(sel_cfg[EBC_POS_TYPE_LO +: 2]))
        else $error("bus type decode wrong");

    a_lengthen_map: assert property (@(posedge clk_in) disable iff (!rst_n) // [R6]
        $past(rst_n) |-> long_strobe_out == $past(sel_cfg[EBC_POS_LENGTHEN]))
        else $error("strobe lengthen decode wrong");

    a_unmapped_sel: assert property (@(posedge clk_in) disable iff (!rst_n)
        $past(rst_n) && !$past(win_ok(win_sel_in))
        |-> cmd_half_delay_out && tri_wait_out && !long_strobe_out && !wide_out && !muxed_out)
        else $error("unmapped window not shown as zero word");

    // Strap checks, taken from the synchronised pin levels
    a_strap_type: assert property (@(posedge clk_in) disable iff (!rst_n) // [R5]
        !s_q.strap_done && s_q.sync_fill[1] && !s_q.pin_sync1[0]
        |=> s_q.cfg[0][EBC_POS_TYPE_LO +: 2] == $past(s_q.pin_sync1[2:1]))
        else $error("window 0 type not strapped");

    a_strap_settled: assert property (@(posedge clk_in) disable iff (!rst_n) // [R5]
        !s_q.sync_fill[1] |=> !s_q.strap_done)
        else $error("strap taken before pin sample settled");

    a_strap_once: assert property (@(posedge clk_in) disable iff (!rst_n) // [R5]
        s_q.strap_done |=> s_q.strap_done)
        else $error("strap taken more than once");

    a_write_dropped: assert property (@(posedge clk_in) disable iff (!rst_n) // [R5]
        !s_q.strap_done && !s_q.sync_fill[1]
        |=> $stable(s_q.cfg))
        else $error("window written before strap");

    a_strap_high: assert property (@(posedge clk_in) disable iff (!rst_n) // [R7]
        !s_q.strap_done && s_q.sync_fill[1] && s_q.pin_sync1[0]
        |=> s_q.cfg[0] == EBC_RESET_VAL)
        else $error("window 0 not zero with pin high");

    a_strap_low: assert property (@(posedge clk_in) disable iff (!rst_n) // [R7]
        !s_q.strap_done && s_q.sync_fill[1] && !s_q.pin_sync1[0]
        |=> s_q.cfg[0][EBC_POS_ACTIVE] && s_q.cfg[0][EBC_POS_LENGTHEN])
        else $error("window 0 active and lengthen not set");

    a_active_strap: assert property (@(posedge clk_in) disable iff (!rst_n) // [R7]
        !s_q.strap_done && s_q.sync_fill[1] && !s_q.pin_sync1[0]
        |=> bus_active_out)
        else $error("bus active not set by strap");

    a_active_high: assert property (@(posedge clk_in) disable iff (!rst_n) // [R7]
        !s_q.strap_done && s_q.sync_fill[1] && s_q.pin_sync1[0]
        |=> !bus_active_out)
        else $error("bus active set with pin high");

    // Register port checks
    a_rdata_idle: assert property (@(posedge clk_in) disable iff (!rst_n)
        !rd_in |=> rdata_out == 16'h0000)
        else $error("read data outside read cycle");

    a_rdata_unmapped: assert property (@(posedge clk_in) disable iff (!rst_n)
        rd_in && !win_ok(addr_in) |=> rdata_out == 16'h0000)
        else $error("unmapped read not zero");

    a_rdata_value: assert property (@(posedge clk_in) disable iff (!rst_n)
        rd_in && win_ok(addr_in) |=> rdata_out == $past(s_q.cfg[addr_in]))
        else $error("read data does not match window");

    a_write_lands: assert property (@(posedge clk_in) disable iff (!rst_n)
        s_q.strap_done && wr_in && win_ok(addr_in)
        |=> s_q.cfg[$past(addr_in)] == ($past(wdata_in) & EBC_WR_MASK))
        else $error("write not stored");

    a_reserved_clear: assert property (@(posedge clk_in) disable iff (!rst_n)
        !reserved_set(s_q.cfg))
        else $error("masked bit stored in window");
endmodule : ebc_top

// ===== ebc_pkg.sv
// Package for the external bus cycle configuration block
package ebc_pkg;
    localparam int EBC_WIN_N = 5;
    localparam logic [2:0] EBC_ADDR_BASE = 3'h0;
    localparam logic [15:0] EBC_RESET_VAL = 16'h0000;
    // Field positions inside one window configuration word
    localparam int EBC_POS_CMD_DELAY = 4;
    localparam int EBC_POS_TRI_WAIT = 5;
    localparam int EBC_POS_TYPE_LO = 6;
    localparam int EBC_POS_LENGTHEN = 9;
    localparam int EBC_POS_ACTIVE = 10;
    localparam logic [15:0] EBC_WR_MASK = 16'hF6FF;
    typedef enum logic [1:0] {
        EBC_DEMUX8 = 2'h0,
        EBC_MUX8 = 2'h1,
        EBC_DEMUX16 = 2'h2,
        EBC_MUX16 = 2'h3
    } ebc_type_e;
endpackage : ebc_pkg

// ===== ebc_decode.sv
// Field decoder for one window configuration word
`timescale 1ns/10ps
module ebc_decode
    import ebc_pkg::*;
(
    input wire logic [15:0] cfg_in,
    output logic cmd_half_delay_out,
    output logic tri_wait_out,
    output logic long_strobe_out,
    output logic wide_out,
    output logic muxed_out
);
    ebc_type_e t;
    always_comb begin
        t = ebc_type_e'(cfg_in[EBC_POS_TYPE_LO +: 2]);
        cmd_half_delay_out = ~cfg_in[EBC_POS_CMD_DELAY]; // [R1] [R2]
        tri_wait_out = ~cfg_in[EBC_POS_TRI_WAIT]; // [R3]
        long_strobe_out = cfg_in[EBC_POS_LENGTHEN]; // [R6]
        wide_out = (t == EBC_DEMUX16) || (t == EBC_MUX16); // [R4]
        muxed_out = (t == EBC_MUX8) || (t == EBC_MUX16); // [R4]
    end
endmodule : ebc_decode

// ===== ebc_mem_model.sv
// Behavioural far-side memory: byte lanes seen for the configured bus
`timescale 1ns/10ps
module ebc_mem_model (
    input wire logic wide_in,
    input wire logic muxed_in,
    output logic [1:0] lanes_out,
    output logic shared_ad_out
);
    // Multiplexing moves address timing only, lane count is unchanged
    assign lanes_out = wide_in ? 2'h2 : 2'h1;
    // Multiplexed bus carries address and data on the same pins
    assign shared_ad_out = muxed_in;
endmodule : ebc_mem_model

// ===== ebc_top_tb.sv
// Self-checking testbench for the window bus configuration block
`timescale 1ns/10ps
module ebc_top_tb;
    import ebc_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, pin = 1'b0;
    logic [2:0] addr = 3'h0, sel = 3'h0;
    logic [15:0] wdata = 16'h0000, rdata;
    logic [1:0] port = 2'h2;
    logic cmd, tri_w, lng, wide, mux, act, shared;
    logic [1:0] lanes;
    int num_errors = 0, tests_run = 0;
    initial forever #5 clk = ~clk;
    ebc_top uut (.clk_in(clk), .resetn_in(rst_n), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr), .rd_in(rd), .external_access_pin_in(pin),
        .config_sample_port_in(port), .win_sel_in(sel), .rdata_out(rdata),
        .cmd_half_delay_out(cmd), .tri_wait_out(tri_w), .long_strobe_out(lng),
        .wide_out(wide), .muxed_out(mux), .bus_active_out(act));
    ebc_mem_model mem (.wide_in(wide), .muxed_in(mux), .lanes_out(lanes),
        .shared_ad_out(shared));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict
    // Pin held well past the two-flop strap sampling on both sides
    task automatic do_reset(input logic p);
        @(posedge clk) rst_n <= 1'b0;
        pin <= p;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
    endtask : do_reset
    task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk) wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk) wr <= 1'b0;
    endtask : wr_reg
    // Read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [2:0] a, input logic [15:0] exp);
        @(posedge clk) rd <= 1'b1;
        addr <= a;
        @(posedge clk) rd <= 1'b0;
        #1 check(rdata, exp);
    endtask : rd_chk
    task automatic dec_chk(input logic [2:0] s, input logic [5:0] exp);
        @(posedge clk) sel <= s;
        repeat (2) @(posedge clk);
        #1 check({10'h000, cmd, tri_w, lng, wide, mux, act}, {10'h000, exp});
    endtask : dec_chk
    task automatic test_strap();
        do_reset(1'b0);
        rd_chk(3'h0, 16'h0680);
        dec_chk(3'h0, 6'h3D);
        $display("test strap done");
    endtask : test_strap
    task automatic test_fields();
        logic [1:0] t;
        for (int i = 0; i < 4; i++) begin
            t = i[1:0];
            wr_reg(3'h1, {6'h00, t[0], 1'b1, t, t[1], t[0], 4'h0});
            rd_chk(3'h1, {6'h00, t[0], 1'b0, t, t[1], t[0], 4'h0});
            dec_chk(3'h1, {~t[0], ~t[1], t[0], t, 1'b1});
            check({14'h0000, lanes}, {14'h0000, (t[1] ? 2'h2 : 2'h1)});
            check({15'h0000, shared}, {15'h0000, t[0]});
        end
        wr_reg(3'h5, 16'hFFFF);
        rd_chk(3'h5, 16'h0000);
        $display("test fields done");
    endtask : test_fields
    task automatic test_pin_high();
        do_reset(1'b1);
        rd_chk(3'h0, 16'h0000);
        dec_chk(3'h0, 6'h30);
        $display("test pin high done");
    endtask : test_pin_high
    initial begin
        #100000;
        num_errors++;
        give_verdict();
    end
    initial begin
        test_strap();
        test_fields();
        test_pin_high();
        give_verdict();
    end
endmodule : ebc_top_tb
